// File: rtl/sbio_port.sv
// Two six-bit general-purpose I/O ports with direction, pull-up and wake logic
// Summary of operation
// - Port reads return pin levels, not latches
// - Any reset sets all direction bits
// - First port bits 7 and 6 read zero
// - Second port bits 7 and 6 read zero
// - First port bit 3 is input only
// - Alternate-function pins read as zero
// - Pull-ups and wake only on bits 0,1,3,4
// - One shared pull-up control and one shared wake control
// - Reset-input bit 3: pull-up on, no wake
// - Direction-load copies accumulator into direction register
// - Direction one tristates, zero drives latch
// - Timer clock pin direction overridden by timer
// - Direction registers write-only, reset to ones
// - Inputs unlatched; output latches hold value
// - Each pin except first port bit 3 independently directed
// - Wake flag set on wake reset, else cleared
// - Bit set/clear writes pin levels to latches
// - Writes at cycle end, reads at start
// - Data latches unchanged by reset
// - Option bit 7 low enables wake
// - Option bit 6 low enables pull-ups
// - Timer source select forces clock pin input
`timescale 1ns/10ps
`include "sbio_defs.svh"

module sbio_port #(
  parameter int WIDTH = 6,
  parameter logic [2:0] TMR_PIN = 3'd2,
  parameter bit TMR_ON_PORT2 = 1'b0
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wake_reset,
  // Register file access from the core
  input wire logic [4:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Bit set/clear instructions
  input wire logic i_bit_set,
  input wire logic i_bit_clr,
  input wire logic [2:0] i_bit_sel,
  // Direction-load and option load
  input wire logic i_dir_load,
  input wire sbio_pkg::sbio_dir_sel_t i_dir_sel,
  input wire logic i_opt_load,
  input wire logic [7:0] i_acc,
  // Configuration word
  input wire logic [5:0] i_alt_fn1,
  input wire logic [5:0] i_alt_fn2,
  input wire logic i_reset_pin_mode,
  // Pins
  input wire logic [5:0] i_pin1,
  input wire logic [5:0] i_pin2,
  output sbio_pkg::sbio_pad_t o_pad1,
  output sbio_pkg::sbio_pad_t o_pad2,
  output logic [5:0] o_pullup1,
  // Status
  output logic o_wake_flag,
  output logic o_wake_event
);

  logic [WIDTH-1:0] dir1_reg, dir2_reg, dirs_reg;
  logic [WIDTH-1:0] lat1_reg, lat2_reg, lat1_next, lat2_next;
  logic [WIDTH-1:0] snap_reg;
  logic [7:0] opt_reg;
  logic wflag_reg;

  function automatic logic [WIDTH-1:0] read_port(input logic [WIDTH-1:0] pins,
                                                input logic [WIDTH-1:0] alt);
    read_port = pins & ~alt;
  endfunction : read_port

  function automatic logic [WIDTH-1:0] bit_op(input logic [WIDTH-1:0] v,
                                             input logic [2:0] b, input logic s);
    logic [WIDTH-1:0] r;
    r = v;
    if (b < 3'(WIDTH)) begin
      r[b] = s;
    end
    bit_op = r;
  endfunction : bit_op

  wire [WIDTH-1:0] rd1 = read_port(i_pin1, i_alt_fn1);
  wire [WIDTH-1:0] rd2 = read_port(i_pin2, i_alt_fn2);
  wire sel1 = (i_addr == `SBIO_ADDR_PORT1);
  wire sel2 = (i_addr == `SBIO_ADDR_PORT2);
  wire bitop = i_bit_set | i_bit_clr;
  // Small part shares first-port pins; last direction load of either wins
  wire [WIDTH-1:0] dir1_eff = dir1_reg & dirs_reg;
  wire tmr_force = opt_reg[`SBIO_OPT_TMR_SRC];
  wire [WIDTH-1:0] tmr_mask = WIDTH'(1) << TMR_PIN;
  wire [WIDTH-1:0] in_only = WIDTH'(1) << `SBIO_INPUT_ONLY_BIT;
  wire [WIDTH-1:0] f1 = (tmr_force && !TMR_ON_PORT2) ? tmr_mask : '0;
  wire [WIDTH-1:0] f2 = (tmr_force && TMR_ON_PORT2) ? tmr_mask : '0;
  wire wake_en = ~opt_reg[`SBIO_OPT_WAKE_DIS];
  wire pull_en = ~opt_reg[`SBIO_OPT_PULL_DIS];
  wire [WIDTH-1:0] wake_mask = `SBIO_WAKE_PIN_MASK & ~(i_reset_pin_mode ? in_only : '0);
  wire mismatch = wake_en && (((i_pin1 ^ snap_reg) & wake_mask) != '0);

  // bit ops write modified pin levels to the full latch
  always_comb begin
    lat1_next = lat1_reg;
    lat2_next = lat2_reg;
    if (bitop && sel1) begin
      lat1_next = bit_op(rd1, i_bit_sel, i_bit_set);
    end else if (i_wr && sel1) begin
      lat1_next = i_wdata[WIDTH-1:0];
    end
    if (bitop && sel2) begin
      lat2_next = bit_op(rd2, i_bit_sel, i_bit_set);
    end else if (i_wr && sel2) begin
      lat2_next = i_wdata[WIDTH-1:0];
    end
  end

  // Latches update at the clock edge ending the cycle; no reset keeps them
  always_ff @(posedge i_mclk) begin
    lat1_reg <= lat1_next;
    lat2_reg <= lat2_next;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      dir1_reg <= `SBIO_DIR_RESET;
      dir2_reg <= `SBIO_DIR_RESET;
      dirs_reg <= `SBIO_DIR_RESET;
      opt_reg <= `SBIO_OPT_RESET;
    end else begin
      if (i_dir_load) begin
        case (i_dir_sel)
          sbio_pkg::SBIO_DIR_SMALL: begin
            dirs_reg <= i_acc[WIDTH-1:0];
            dir1_reg <= i_acc[WIDTH-1:0];
          end
          sbio_pkg::SBIO_DIR_PORT1: begin
            dir1_reg <= i_acc[WIDTH-1:0];
            dirs_reg <= i_acc[WIDTH-1:0];
          end
          sbio_pkg::SBIO_DIR_PORT2: dir2_reg <= i_acc[WIDTH-1:0];
          default: ;
        endcase
      end
      if (i_opt_load) begin
        opt_reg <= i_acc;
      end
    end
  end

  // Wake flag held until next reset, which decides its value
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wflag_reg <= 1'b0;
      snap_reg <= '0;
    end else begin
      if (i_rd && sel1) begin
        snap_reg <= i_pin1;
      end
      if (i_wake_reset) begin
        wflag_reg <= 1'b1;
      end
    end
  end

  assign o_rdata = (i_addr == `SBIO_ADDR_STATUS) ? {wflag_reg, 7'h00} :
                   sel1 ? {2'b00, rd1} : sel2 ? {2'b00, rd2} : 8'h00;
  assign o_pad1.out = lat1_reg;
  assign o_pad1.oe_n = dir1_eff | in_only | f1;
  assign o_pad2.out = lat2_reg;
  assign o_pad2.oe_n = dir2_reg | f2;
  assign o_pullup1 = (pull_en ? `SBIO_WAKE_PIN_MASK : 6'h00) |
                     (i_reset_pin_mode ? in_only : 6'h00);
  assign o_wake_flag = wflag_reg;
  assign o_wake_event = mismatch;

endmodule : sbio_port

// File: rtl/sbio_defs.svh
// Offsets, field positions, reset values for the six-bit I/O port block
`ifndef SBIO_DEFS_SVH
`define SBIO_DEFS_SVH
`define SBIO_ADDR_STATUS 5'h03
`define SBIO_ADDR_PORT1 5'h06
`define SBIO_ADDR_PORT2 5'h07
`define SBIO_DIR_RESET 6'h3f
`define SBIO_OPT_RESET 8'hff
`define SBIO_OPT_WAKE_DIS 7
`define SBIO_OPT_PULL_DIS 6
`define SBIO_OPT_TMR_SRC 5
`define SBIO_STATUS_WAKE 7
`define SBIO_INPUT_ONLY_BIT 3
`define SBIO_WAKE_PIN_MASK 6'h1b
`endif

// File: rtl/sbio_pkg.sv
// Types shared by the six-bit I/O port block
package sbio_pkg;
  typedef enum logic [1:0] {
    SBIO_DIR_SMALL = 2'b00,
    SBIO_DIR_PORT1 = 2'b01,
    SBIO_DIR_PORT2 = 2'b10
  } sbio_dir_sel_t;
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe_n;
  } sbio_pad_t;
endpackage : sbio_pkg

// File: tb/sbio_chk_sva.sv
// Port-level assertions for the six-bit I/O port block
`timescale 1ns/10ps
module sbio_chk (
  // Core side
  input wire logic i_mclk, i_rst, i_wr, i_bit_set, i_bit_clr, i_dir_load, i_opt_load,
  input wire logic i_reset_pin_mode,
  input wire logic [4:0] i_addr,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_wdata, i_acc, o_rdata,
  input wire sbio_pkg::sbio_dir_sel_t i_dir_sel,
  // Pins
  input wire logic [5:0] i_pin1, i_alt_fn1, o_pullup1,
  input wire sbio_pkg::sbio_pad_t o_pad1, o_pad2
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_rd; i_addr == 5'h06 |-> o_rdata == {2'h0, i_pin1 & ~i_alt_fn1}; endproperty
  a_rd: assert property (p_rd) else $error("port read");
  property p_rst; $fell(i_rst) |-> o_pad1.oe_n == 6'h3f && o_pad2.oe_n == 6'h3f; endproperty
  a_rst: assert property (p_rst) else $error("reset direction");
  property p_in3; i_dir_load |=> o_pad1.oe_n[3]; endproperty
  a_in3: assert property (p_in3) else $error("input-only driven");
  property p_dir; i_dir_load && i_dir_sel == sbio_pkg::SBIO_DIR_PORT2
    |=> o_pad2.oe_n == $past(i_acc[5:0]); endproperty
  a_dir: assert property (p_dir) else $error("direction load");
  property p_hold; !i_wr && !i_bit_set && !i_bit_clr |=> $stable(o_pad1.out); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_wr; i_wr && !i_bit_set && !i_bit_clr && i_addr == 5'h06
    |=> o_pad1.out == $past(i_wdata[5:0]); endproperty
  a_wr: assert property (p_wr) else $error("port write");
  property p_set; i_bit_set && i_addr == 5'h06
    |=> o_pad1.out == ($past(i_pin1) | 6'h01 << $past(i_bit_sel)); endproperty
  a_set: assert property (p_set) else $error("bit set");
  property p_pu; i_opt_load && !i_reset_pin_mode
    |=> o_pullup1 == ($past(i_acc[6]) ? 6'h00 : 6'h1b); endproperty
  a_pu: assert property (p_pu) else $error("pull-up");
endmodule : sbio_chk
bind sbio_port sbio_chk i_chk (.*);

// File: tb/sbio_pins.sv
// Off-chip circuitry that drives every pin the device leaves undriven
`timescale 1ns/10ps
module sbio_pins (
  // Device pads
  input wire sbio_pkg::sbio_pad_t i_pad1, i_pad2,
  // External levels
  input wire logic [5:0] i_ext1, i_ext2,
  // Resolved pins
  output logic [5:0] o_pin1, o_pin2
);
  // Outside source drives every tristated pin at all times, never released
  assign o_pin1 = i_pad1.oe_n & i_ext1 | ~i_pad1.oe_n & i_pad1.out;
  assign o_pin2 = i_pad2.oe_n & i_ext2 | ~i_pad2.oe_n & i_pad2.out;
endmodule : sbio_pins

// File: tb/tb_top.sv
// Self-checking bench for the six-bit I/O port block
`timescale 1ns/10ps
module tb_top;
  localparam logic [5:0] RD = 6'h20, WR = 6'h10, SET = 6'h08, CLR = 6'h04, DIR = 6'h02;
  localparam logic [5:0] OPT = 6'h01;
  logic i_mclk = 0, i_rst = 1, i_wake_reset = 0, i_rd = 0, i_wr = 0, i_bit_set = 0;
  logic i_bit_clr = 0, i_dir_load = 0, i_opt_load = 0, o_wake_flag;
  logic i_reset_pin_mode = 0, o_wake_event;
  logic [4:0] i_addr = 5'h00;
  logic [2:0] i_bit_sel = 3'h0;
  logic [7:0] i_wdata = 8'h00, i_acc = 8'h00, o_rdata;
  logic [5:0] i_alt_fn1 = 6'h00, i_pin1, i_pin2, o_pullup1, ext1 = 6'h00, ext2 = 6'h00;
  sbio_pkg::sbio_dir_sel_t i_dir_sel = sbio_pkg::SBIO_DIR_SMALL;
  sbio_pkg::sbio_pad_t o_pad1, o_pad2;
  int mismatches = 0;
  int n_tests = 0;
  always #50 i_mclk = ~i_mclk;
  sbio_port i_dut (.*, .i_alt_fn2(6'h00));
  sbio_pins i_pins (.i_pad1(o_pad1), .i_pad2(o_pad2), .i_ext1(ext1), .i_ext2(ext2),
    .o_pin1(i_pin1), .o_pin2(i_pin2));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One strobe cycle; data doubles as accumulator and bit number
  task automatic op(input logic [4:0] a, input logic [7:0] d, input logic [5:0] s);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_acc <= d;
    i_bit_sel <= d[2:0];
    i_dir_sel <= sbio_pkg::sbio_dir_sel_t'(a[1:0]);
    {i_rd, i_wr, i_bit_set, i_bit_clr, i_dir_load, i_opt_load} <= s;
    @(posedge i_mclk);
    {i_rd, i_wr, i_bit_set, i_bit_clr, i_dir_load, i_opt_load} <= 6'h00;
    #1;
  endtask : op
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    // Latches have no reset; load both while in reset so they start known
    i_addr <= 5'h06;
    i_wr <= 1;
    @(posedge i_mclk);
    i_addr <= 5'h07;
    @(posedge i_mclk);
    i_wr <= 0;
    repeat (3) @(posedge i_mclk);
    i_rst <= 0;
    op(5'h03, 8'h00, RD);
    chk("st", 8'h00, o_rdata);
    op(5'h06, 8'h15, WR);
    chk("out1", 8'h15, {2'h0, o_pad1.out});
    op(5'h01, 8'h00, DIR);
    chk("oe1", 8'h0c, {2'h0, o_pad1.oe_n});
    op(5'h00, 8'h00, OPT);
    chk("oe1", 8'h08, {2'h0, o_pad1.oe_n});
    chk("pu", 8'h1b, {2'h0, o_pullup1});
    chk("wake", 8'h01, {7'h00, o_wake_event});
    op(5'h00, 8'hff, OPT);
    op(5'h01, 8'h3f, DIR);
    ext1 <= 6'h2a;
    op(5'h06, 8'h00, RD);
    chk("rd1", 8'h2a, o_rdata);
    i_alt_fn1 <= 6'h03;
    op(5'h06, 8'h00, RD);
    chk("rd1", 8'h28, o_rdata);
    i_alt_fn1 <= 6'h00;
    op(5'h07, 8'h2a, WR);
    op(5'h02, 8'h05, DIR);
    ext2 <= 6'h3f;
    op(5'h07, 8'h00, RD);
    chk("rd2", 8'h2f, o_rdata);
    op(5'h06, 8'h00, SET);
    chk("out1", 8'h2b, {2'h0, o_pad1.out});
    op(5'h06, 8'h05, CLR);
    chk("out1", 8'h0a, {2'h0, o_pad1.out});
    // Wake-caused reset: flag set, latches survive
    @(posedge i_mclk);
    i_rst <= 1;
    @(posedge i_mclk);
    i_rst <= 0;
    i_wake_reset <= 1;
    @(posedge i_mclk);
    i_wake_reset <= 0;
    op(5'h03, 8'h00, RD);
    chk("st", 8'h80, o_rdata);
    chk("out1", 8'h0a, {2'h0, o_pad1.out});
    chk("oe1", 8'h3f, {2'h0, o_pad1.oe_n});
    // Bit 3 as reset input: pull-up forced, no wake from it
    i_reset_pin_mode <= 1;
    op(5'h00, 8'h00, OPT);
    op(5'h06, 8'h00, RD);
    ext1 <= 6'h22;
    #1;
    chk("wake", 8'h00, {7'h00, o_wake_event});
    ext1 <= 6'h23;
    #1;
    chk("wake", 8'h01, {7'h00, o_wake_event});
    chk("pu", 8'h1b, {2'h0, o_pullup1});
    op(5'h00, 8'hff, OPT);
    chk("pu", 8'h08, {2'h0, o_pullup1});
    // Plain reset clears the wake flag
    @(posedge i_mclk);
    i_rst <= 1;
    @(posedge i_mclk);
    i_rst <= 0;
    op(5'h03, 8'h00, RD);
    chk("st", 8'h00, o_rdata);
    tally_and_finish();
  end
endmodule : tb_top
